// ==== dv/lcd_host_model.sv ====
// Host processor model: drives the parallel bus of the command decoder.
// Assumes callers are clock-synchronous; e_style picks the bus style.
`timescale 1ns/100ps
module lcd_host_model (
   input  wire logic       clk,
   input  wire logic       e_style,
   input  wire logic [7:0] rd_data,
   output logic            cs_n,
   output logic            rd_n,
   output logic            wr_n,
   output logic            dts,
   output logic [7:0]      wdata
);
   initial
   begin
      cs_n  = 1'b1;
      rd_n  = 1'b1;
      wr_n  = 1'b1;
      dts   = 1'b0;
      wdata = 8'h00;
   end

   // Bus released for two edges; data lines show no stale byte
   task automatic idle();
      @(posedge clk);
      #1;
      cs_n  = 1'b1;
      rd_n  = ~e_style;  // Enable low when idle in enable style
      wr_n  = 1'b1;
      wdata = ~wdata;
      repeat (2) @(posedge clk);
   endtask : idle

   // Write: both styles use rd_n high, wr_n low
   task automatic put(input logic cmd, input logic [7:0] b);
      @(posedge clk);
      #1;
      cs_n  = 1'b0;
      dts   = cmd;
      wdata = b;
      rd_n  = 1'b1;
      wr_n  = 1'b0;
      repeat (2) @(posedge clk);
      idle();
   endtask : put

   // Read: data taken at the fourth of five held edges
   task automatic get(output logic [7:0] b);
      @(posedge clk);
      #1;
      cs_n = 1'b0;
      dts  = 1'b0;
      rd_n = e_style;
      wr_n = 1'b1;
      repeat (4) @(posedge clk);
      b = rd_data;
      idle();
   endtask : get
endmodule : lcd_host_model

// ==== dv/testbench.sv ====
// Self-checking bench of the command decoder with a host model.
// Assumes a display memory that answers a read pulse one cycle later.
`timescale 1ns/100ps
module testbench;
   import lcd_cmd_pkg::*;
   logic        clk, rst, sel_lo, sel_hi, cs_n, rd_n, wr_n, dts, oe;
   logic [7:0]  din, dout, flash, pshift, lmix, b;
   logic [7:0]  rdat = 8'h00;
   logic [7:0]  init_p [INIT_BYTES];
   logic [7:0]  scroll_p [SCROLL_BYTES];
   logic        standby, disp_on, wr_p, rd_p;
   logic [15:0] char_base, caddr, wr_addr;
   logic [7:0]  wr_data;
   logic        rvalid = 1'b0;
   int          wr_cnt = 0;
   int          mismatches = 0;
   int          n_checks = 0;
   cursor_dir_t cdir;
   mem_req_t    mreq;

   always #2.5 clk = ~clk;

   lcd_host_model lcd_host_model_inst (.clk(clk), .e_style(sel_lo | sel_hi),
      .rd_data(dout), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
      .dts(dts), .wdata(din));

   lcd_command_decoder lcd_command_decoder_inst (.clk(clk), .rst(rst),
      .bus_style_select_low(sel_lo), .bus_style_select_high(sel_hi),
      .chip_select_n(cs_n), .host_rd_n(rd_n), .host_wr_n(wr_n),
      .data_type_select(dts), .host_data_in(din), .host_data_out(dout),
      .host_data_oe(oe), .init_param(init_p), .scroll_param(scroll_p),
      .standby(standby), .display_on(disp_on), .flash_ctrl(flash),
      .char_ram_base(char_base), .cursor_dir(cdir),
      .pixel_shift(pshift), .layer_mix(lmix), .cursor_addr(caddr),
      .mem_req(mreq), .mem_wr_pulse(wr_p), .mem_rd_pulse(rd_p),
      .mem_rd_valid(rvalid), .mem_rd_data(rdat));

   // ************************************************************
   // Display memory stand-in: read data is the address folded
   // ************************************************************
   always @(posedge clk)
   begin
      rvalid <= rd_p;
      if (rd_p)
         rdat <= mreq.addr[7:0] ^ 8'h5a;
      if (wr_p)
      begin
         wr_addr <= mreq.addr;
         wr_data <= mreq.data;
         wr_cnt  <= wr_cnt + 1;
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic t_init();
      lcd_host_model_inst.put(1'b1, CODE_STANDBY);
      chk(16'(standby), 16'h0001);
      lcd_host_model_inst.put(1'b1, CODE_INIT);
      chk(16'(standby), 16'h0000);
      for (int i = 0; i < INIT_BYTES; i++)
      begin
         lcd_host_model_inst.put(1'b0, 8'h10 + 8'(i));
         chk(16'(init_p[i]), 16'h0010 + 16'(i));
      end
      $display("test init done");
   endtask : t_init

   task automatic t_display();
      lcd_host_model_inst.put(1'b1, 8'h59);
      lcd_host_model_inst.put(1'b0, 8'ha5);
      chk({7'h00, disp_on, flash}, 16'h01a5);
      lcd_host_model_inst.put(1'b1, 8'h58);
      chk(16'(disp_on), 16'h0000);
      $display("test display done");
   endtask : t_display

   // Lone first byte must be dropped when a command intervenes
   task automatic t_pairs();
      lcd_host_model_inst.put(1'b1, CODE_CHAR_BASE);
      lcd_host_model_inst.put(1'b0, 8'h34);
      chk(char_base, 16'h0000);
      lcd_host_model_inst.put(1'b1, CODE_CHAR_BASE);
      lcd_host_model_inst.put(1'b0, 8'h78);
      lcd_host_model_inst.put(1'b0, 8'h12);
      chk(char_base, 16'h1278);
      lcd_host_model_inst.put(1'b1, CODE_SCROLL);
      for (int i = 0; i < 4; i++)
         lcd_host_model_inst.put(1'b0, 8'h20 + 8'(i));
      lcd_host_model_inst.put(1'b1, CODE_LAYER_MIX);
      lcd_host_model_inst.put(1'b0, 8'h66);
      chk(16'(lmix), 16'h0066);
      chk({scroll_p[0], scroll_p[1]}, 16'h2021);
      chk({scroll_p[2], scroll_p[3]}, 16'h2200);
      $display("test pairs done");
   endtask : t_pairs

   task automatic t_dir_shift();
      for (int i = 0; i < 4; i++)
      begin
         lcd_host_model_inst.put(1'b1, 8'h4c + 8'(i));
         chk(16'(cdir), 16'(i));
      end
      lcd_host_model_inst.put(1'b1, CODE_PIXEL_SHIFT);
      lcd_host_model_inst.put(1'b0, 8'h33);
      chk(16'(pshift), 16'h0033);
      $display("test dir done");
   endtask : t_dir_shift

   task automatic t_cursor();
      lcd_host_model_inst.put(1'b1, CODE_CURSOR_WR);
      lcd_host_model_inst.put(1'b0, 8'h20);
      lcd_host_model_inst.put(1'b0, 8'h01);
      chk(caddr, 16'h0120);
      lcd_host_model_inst.put(1'b1, CODE_CURSOR_WR);
      lcd_host_model_inst.put(1'b0, 8'h55);
      chk(caddr, 16'h0155);
      lcd_host_model_inst.put(1'b1, CODE_CURSOR_RD);
      fork
         lcd_host_model_inst.get(b);
         begin
            repeat (3) @(posedge clk);
            chk(16'(oe), 16'h0001);
         end
      join
      chk(16'(b), 16'h0055);
      chk(16'(oe), 16'h0000);
      lcd_host_model_inst.get(b);
      chk(16'(b), 16'h0001);
      $display("test cursor done");
   endtask : t_cursor

   // Stream runs on, cursor stepping right, until the next command
   task automatic t_memory();
      lcd_host_model_inst.put(1'b1, 8'h4c);
      lcd_host_model_inst.put(1'b1, CODE_CURSOR_WR);
      lcd_host_model_inst.put(1'b0, 8'h00);
      lcd_host_model_inst.put(1'b0, 8'h02);
      lcd_host_model_inst.put(1'b1, CODE_MEM_WRITE);
      for (int i = 0; i < 3; i++)
      begin
         lcd_host_model_inst.put(1'b0, 8'hc0 + 8'(i));
         chk(wr_addr, 16'h0200 + 16'(i));
         chk({8'(wr_cnt), wr_data}, {8'(i + 1), 8'hc0 + 8'(i)});
      end
      chk(caddr, 16'h0203);
      lcd_host_model_inst.put(1'b1, CODE_MEM_READ);
      for (int i = 3; i < 5; i++)
      begin
         lcd_host_model_inst.get(b);
         chk(16'(b), 16'(8'(i) ^ 8'h5a));
      end
      chk(16'(wr_cnt), 16'h0003);
      $display("test memory done");
   endtask : t_memory

   task automatic t_e_style();
      #1;
      sel_lo = 1'b1;
      lcd_host_model_inst.idle();
      lcd_host_model_inst.put(1'b1, CODE_PIXEL_SHIFT);
      lcd_host_model_inst.put(1'b0, 8'h77);
      chk(16'(pshift), 16'h0077);
      #1;
      sel_lo = 1'b0;
      sel_hi = 1'b1;
      lcd_host_model_inst.put(1'b1, CODE_CURSOR_RD);
      lcd_host_model_inst.get(b);
      chk(16'(b), 16'h0005);
      $display("test bus style done");
   endtask : t_e_style

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : print_verdict

   initial
   begin
      clk    = 1'b0;
      rst    = 1'b1;
      sel_lo = 1'b0;
      sel_hi = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      t_init();
      t_display();
      t_pairs();
      t_dir_shift();
      t_cursor();
      t_memory();
      t_e_style();
      print_verdict();
   end

   // Whole run needs about 1.7 us; over twenty times that means a hang
   initial
   begin
      #40000;
      mismatches++;
      print_verdict();
   end
endmodule : testbench

// ==== src/lcd_cmd_pkg.sv ====
// Package for the LCD command decoder: command codes, counts, structs.
// Assumes one clock domain and a host bus sampled synchronously.
package lcd_cmd_pkg;

   // ************************************************************
   // Command codes
   // ************************************************************
   localparam logic [7:0] CODE_INIT        = 8'h40;
   localparam logic [7:0] CODE_MEM_WRITE   = 8'h42;
   localparam logic [7:0] CODE_MEM_READ    = 8'h43;
   localparam logic [7:0] CODE_SCROLL      = 8'h44;
   localparam logic [7:0] CODE_CURSOR_WR   = 8'h46;
   localparam logic [7:0] CODE_CURSOR_RD   = 8'h47;
   localparam logic [5:0] CODE_DIR_BASE    = 6'h13;  // 4c..4f >> 2
   localparam logic [7:0] CODE_STANDBY     = 8'h53;
   localparam logic [6:0] CODE_DISP_BASE   = 7'h2c;  // 58/59 >> 1
   localparam logic [7:0] CODE_PIXEL_SHIFT = 8'h5a;
   localparam logic [7:0] CODE_LAYER_MIX   = 8'h5b;
   localparam logic [7:0] CODE_CHAR_BASE   = 8'h5c;

   // ************************************************************
   // Parameter counts and reset values
   // ************************************************************
   localparam int unsigned INIT_BYTES   = 8;
   localparam int unsigned SCROLL_BYTES = 10;
   localparam logic [7:0]  RESET_BYTE   = 8'h00;
   localparam logic [1:0]  RESET_DIR    = 2'h0;
   // Init bytes 6 and 7 are the pitch bytes, taken bytewise; only byte 6 feeds the cursor step
   localparam int unsigned PITCH_LO_IDX = 6;
   localparam int unsigned PITCH_HI_IDX = 7;

   typedef enum logic [1:0] {
      DIR_RIGHT,
      DIR_LEFT,
      DIR_UP,
      DIR_DOWN
   } cursor_dir_t;

   typedef struct packed {
      logic [7:0] data;
      logic       is_command;   // data_type_select high
   } host_byte_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  data;
   } mem_req_t;

endpackage : lcd_cmd_pkg

// ==== src/lcd_command_decoder.sv ====
// Command decoder of a dot-matrix LCD controller: host bytes to parameters.
// Assumes host pins synchronous to clk; memory side answers on mem_rd_valid.
`timescale 1ns/100ps

// Summary of operation
// R1: 40h init with eight bytes; 53h standby
// R2: 58h/59h display off/on, one flash byte
// R3: Paired bytes update together; lone byte dropped
// R4: 5Ch sets char RAM base, two bytes
// R5: 4Ch-4Fh set cursor direction, no parameters
// R6: 5Ah pixel shift, one parameter byte
// R7: 5Bh layer mix, one parameter byte
// R8: Cursor address bytes handled individually
// R9: 42h streams bytes into display memory
// R10: 43h streams display memory to host reads
// R11: Each unpaired parameter takes effect on receipt
// R12: New command keeps received, leaves rest
// R13: Pitch bytes are independent single bytes
// R14: Two selects choose strobe or enable style
// R15: Host marks commands with select high
// R16: Stream continues, cursor moves, until command
module lcd_command_decoder
   import lcd_cmd_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                bus_style_select_low,
   input  wire logic                bus_style_select_high,
   input  wire logic                chip_select_n,
   input  wire logic                host_rd_n,
   input  wire logic                host_wr_n,
   input  wire logic                data_type_select,
   input  wire logic [7:0]          host_data_in,
   output logic      [7:0]          host_data_out,
   output logic                     host_data_oe,
   output logic      [7:0]          init_param [INIT_BYTES],
   output logic      [7:0]          scroll_param [SCROLL_BYTES],
   output logic                     standby,
   output logic                     display_on,
   output logic      [7:0]          flash_ctrl,
   output logic      [15:0]         char_ram_base,
   output cursor_dir_t              cursor_dir,
   output logic      [7:0]          pixel_shift,
   output logic      [7:0]          layer_mix,
   output logic      [15:0]         cursor_addr,
   output lcd_cmd_pkg::mem_req_t    mem_req,
   output logic                     mem_wr_pulse,
   output logic                     mem_rd_pulse,
   input  wire logic                mem_rd_valid,
   input  wire logic [7:0]          mem_rd_data
);

   // ************************************************************
   // Host bus strobes
   // ************************************************************
   // Select pair both low: separate strobes; otherwise enable + r/w.
   logic       sep_strobes;
   logic       wr_level;
   logic       rd_level;
   logic       wr_q;
   logic       rd_q;
   logic       wr_ev;
   logic       rd_ev;
   host_byte_t hb;

   assign sep_strobes = !bus_style_select_low && !bus_style_select_high;
   always_comb
   begin
      if (sep_strobes)
      begin
         wr_level = !chip_select_n && !host_wr_n && host_rd_n;  // [R14]
         rd_level = !chip_select_n && !host_rd_n && host_wr_n;  // [R14]
      end
      else
      begin
         wr_level = !chip_select_n && host_rd_n && !host_wr_n;  // [R14]
         rd_level = !chip_select_n && host_rd_n && host_wr_n;   // [R14]
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
      end
      else
      begin
         wr_q <= wr_level;
         rd_q <= rd_level;
      end
   end

   // One event per access, taken on the strobe's leading edge
   assign wr_ev = wr_level && !wr_q;
   assign rd_ev = rd_level && !rd_q;
   assign hb.data       = host_data_in;
   assign hb.is_command = data_type_select;             // [R15]

   wire cmd_ev   = wr_ev && hb.is_command;
   wire param_ev = wr_ev && !hb.is_command;

   // ************************************************************
   // Command register and parameter index
   // ************************************************************
   logic [7:0] cmd_q;
   logic [3:0] idx_q;
   logic [7:0] pend_q;   // first half of a paired item

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cmd_q <= 8'h00;
         idx_q <= 4'h0;
      end
      else if (cmd_ev)
      begin
         cmd_q <= hb.data;                              // [R12]
         idx_q <= 4'h0;
      end
      else if (param_ev && idx_q != 4'hf)
         idx_q <= idx_q + 4'h1;
      else if (rd_ev && cmd_q == CODE_CURSOR_RD && idx_q != 4'hf)
         idx_q <= idx_q + 4'h1;                         // [R8]
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         pend_q <= RESET_BYTE;
      else if (param_ev)
         pend_q <= hb.data;
   end

   // Paired item completes on an odd index, except scroll pair 3/4; the first byte waits in pend_q
   function automatic logic pair_second(input logic [3:0] i);
      pair_second = i[0];
   endfunction : pair_second

   // ************************************************************
   // Parameter registers
   // ************************************************************
   // Init: bytes 0..5 single; 6/7 pitch single (R13). Others land now.
   generate
      for (genvar g = 0; g < INIT_BYTES; g++)
      begin : g_init
         always_ff @(posedge clk)
         begin
            if (rst)
               init_param[g] <= RESET_BYTE;
            else if (param_ev && cmd_q == CODE_INIT
                     && idx_q == 4'(g))
               init_param[g] <= hb.data;                 // [R1] [R11] [R13]
         end
      end
      // Scroll holds address pairs at 0/1,3/4,6/7,8/9; 2 and 5 are single.
      for (genvar s = 0; s < SCROLL_BYTES; s++)
      begin : g_scroll
         localparam bit IS_PAIR_LO = (s == 0) || (s == 3)
                                     || (s == 6) || (s == 8);
         localparam bit IS_PAIR_HI = (s == 1) || (s == 4)
                                     || (s == 7) || (s == 9);
         always_ff @(posedge clk)
         begin
            if (rst)
               scroll_param[s] <= RESET_BYTE;
            else if (param_ev && cmd_q == CODE_SCROLL)
            begin
               if (!IS_PAIR_LO && !IS_PAIR_HI && idx_q == 4'(s))
                  scroll_param[s] <= hb.data;            // [R11]
               else if (IS_PAIR_HI && idx_q == 4'(s))
                  scroll_param[s] <= hb.data;            // [R3]
               else if (IS_PAIR_LO && idx_q == 4'(s + 1))
                  scroll_param[s] <= pend_q;             // [R3]
            end
         end
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         standby    <= 1'b0;
         display_on <= 1'b0;
         flash_ctrl <= RESET_BYTE;
         cursor_dir <= DIR_RIGHT;
      end
      else if (cmd_ev)
      begin
         if (hb.data == CODE_STANDBY)
            standby <= 1'b1;                             // [R1]
         else if (hb.data == CODE_INIT)
         begin
            standby    <= 1'b0;
            display_on <= 1'b0;
         end
         else if (hb.data[7:1] == CODE_DISP_BASE)
            display_on <= hb.data[0];                    // [R2]
         else if (hb.data[7:2] == CODE_DIR_BASE)
            cursor_dir <= cursor_dir_t'(hb.data[1:0]);   // [R5]
      end
      else if (param_ev && cmd_q[7:1] == CODE_DISP_BASE && idx_q == 4'h0)
         flash_ctrl <= hb.data;                          // [R2]
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         char_ram_base <= 16'h0000;
         pixel_shift   <= RESET_BYTE;
         layer_mix     <= RESET_BYTE;
      end
      else if (param_ev)
      begin
         if (cmd_q == CODE_CHAR_BASE && idx_q[3:1] == 3'h0
             && pair_second(idx_q))
            char_ram_base <= {hb.data, pend_q};          // [R3] [R4]
         if (cmd_q == CODE_PIXEL_SHIFT && idx_q == 4'h0)
            pixel_shift <= hb.data;                      // [R6]
         if (cmd_q == CODE_LAYER_MIX && idx_q == 4'h0)
            layer_mix <= hb.data;                        // [R7]
      end
   end

   // ************************************************************
   // Cursor and memory streaming
   // ************************************************************
   wire in_write = (cmd_q == CODE_MEM_WRITE);
   wire in_read  = (cmd_q == CODE_MEM_READ);
   wire stream_wr = param_ev && in_write;                // [R9]
   wire stream_rd = rd_ev && in_read;                    // [R10]

   function automatic logic [15:0] step(input logic [15:0] a,
                                        input cursor_dir_t d,
                                        input logic [7:0]  pitch);
      unique case (d)
         DIR_RIGHT: step = a + 16'h0001;
         DIR_LEFT:  step = a - 16'h0001;
         DIR_UP:    step = a - {8'h00, pitch};
         DIR_DOWN:  step = a + {8'h00, pitch};
      endcase
   endfunction : step

   always_ff @(posedge clk)
   begin
      if (rst)
         cursor_addr <= 16'h0000;
      else if (param_ev && cmd_q == CODE_CURSOR_WR && idx_q == 4'h0)
         cursor_addr[7:0] <= hb.data;                    // [R8]
      else if (param_ev && cmd_q == CODE_CURSOR_WR && idx_q == 4'h1)
         cursor_addr[15:8] <= hb.data;                   // [R8]
      else if (stream_wr || stream_rd)
         cursor_addr <= step(cursor_addr, cursor_dir,
                             init_param[PITCH_LO_IDX]);  // [R16]
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mem_req      <= '0;
         mem_wr_pulse <= 1'b0;
         mem_rd_pulse <= 1'b0;
      end
      else
      begin
         mem_wr_pulse <= stream_wr;
         mem_rd_pulse <= (cmd_ev && hb.data == CODE_MEM_READ) || stream_rd;
         if (stream_wr)
            mem_req <= '{addr: cursor_addr, data: hb.data};  // [R9]
         else if (cmd_ev && hb.data == CODE_MEM_READ)
            mem_req.addr <= cursor_addr;                 // [R10]
         else if (stream_rd)
            mem_req.addr <= step(cursor_addr, cursor_dir,
                                 init_param[PITCH_LO_IDX]);
      end
   end

   // ************************************************************
   // Host read data
   // ************************************************************
   // Read data is the prefetched byte; cursor reads give the address.
   // Held for the whole read access so a late prefetch cannot tear it.
   logic [7:0] rd_buf_q;
   always_ff @(posedge clk)
   begin
      if (rst)
         rd_buf_q <= RESET_BYTE;
      else if (mem_rd_valid)
         rd_buf_q <= mem_rd_data;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         host_data_out <= RESET_BYTE;
      else if (!rd_level)
      begin
         if (cmd_q == CODE_CURSOR_RD)
            host_data_out <= pair_second(idx_q) ? cursor_addr[15:8]
                                                : cursor_addr[7:0];  // [R8]
         else
            host_data_out <= rd_buf_q;                   // [R10]
      end
   end

   assign host_data_oe = rd_level;

   // ************************************************************
   // Checks
   // ************************************************************
   a_standby_entry: assert property (                    // [R1]
      @(posedge clk) disable iff (rst)
      cmd_ev && hb.data == CODE_STANDBY |=> standby)
      else $error("standby not entered");
   a_display_bit: assert property (                      // [R2]
      @(posedge clk) disable iff (rst)
      cmd_ev && hb.data[7:1] == CODE_DISP_BASE
      |=> display_on == $past(hb.data[0]))
      else $error("display bit wrong");
   a_pair_lone: assert property (                        // [R3]
      @(posedge clk) disable iff (rst)
      param_ev && cmd_q == CODE_CHAR_BASE && idx_q == 4'h0
      |=> $stable(char_ram_base))
      else $error("lone byte applied");
   a_dir_set: assert property (                          // [R5]
      @(posedge clk) disable iff (rst)
      cmd_ev && hb.data[7:2] == CODE_DIR_BASE
      |=> cursor_dir == cursor_dir_t'($past(hb.data[1:0])))
      else $error("direction wrong");
   a_shift_set: assert property (                        // [R6]
      @(posedge clk) disable iff (rst)
      param_ev && cmd_q == CODE_PIXEL_SHIFT && idx_q == 4'h0
      |=> pixel_shift == $past(hb.data))
      else $error("pixel shift wrong");
   a_mix_set: assert property (                          // [R7]
      @(posedge clk) disable iff (rst)
      param_ev && cmd_q == CODE_LAYER_MIX && idx_q == 4'h0
      |=> layer_mix == $past(hb.data))
      else $error("layer mix wrong");
   a_cursor_low: assert property (                       // [R8]
      @(posedge clk) disable iff (rst)
      param_ev && cmd_q == CODE_CURSOR_WR && idx_q == 4'h0
      |=> cursor_addr[15:8] == $past(cursor_addr[15:8]))
      else $error("cursor high disturbed");
   a_write_stream: assert property (                     // [R9]
      @(posedge clk) disable iff (rst)
      stream_wr |=> mem_wr_pulse && mem_req.data == $past(hb.data))
      else $error("memory write missed");
   a_read_hold: assert property (                        // [R10]
      @(posedge clk) disable iff (rst)
      rd_level |=> $stable(host_data_out))
      else $error("read data changed in access");
   a_init_now: assert property (                         // [R11]
      @(posedge clk) disable iff (rst)
      param_ev && cmd_q == CODE_INIT && idx_q == 4'h0
      |=> init_param[0] == $past(hb.data))
      else $error("init byte late");

endmodule : lcd_command_decoder
